// [verilog/cpu_core_pkg.sv]
// Shared constants, opcodes and state codes of the fetch and execute core
package cpu_core_pkg;
   localparam int PC_W = 23;
   localparam int IW = 24;
   localparam int DW = 16;
   localparam int NREG = 16;
   localparam logic [3:0] SP_IDX = 4'hf;
   // Implemented program words behind the program counter (device dependent)
   localparam logic [22:0] PROG_IMPL_WORDS = 23'h008000;
   localparam logic [22:0] RESET_VECTOR = 23'h000000;
   localparam logic [22:0] IRQ_VECTOR = 23'h000004;
   localparam logic [15:0] STACK_STEP = 16'h0002;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   // Divide steps run while the loop count is at or below this value
   localparam logic [15:0] DIV_STEP_LAST = 16'h000f;
   localparam logic [23:0] INSTR_NOP = 24'h000000;
   // Field positions in the instruction word
   localparam int F_OP = 20;
   localparam int F_SUB = 16;
   localparam int F_WD = 12;
   localparam int F_WA = 8;
   localparam int F_WB = 4;
   localparam int F_RETI = 19;
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_LIT = 4'h1;
   localparam logic [3:0] OP_LOAD = 4'h2;
   localparam logic [3:0] OP_MEMALU = 4'h3;
   localparam logic [3:0] OP_STORE = 4'h4;
   localparam logic [3:0] OP_GOTO = 4'h5;
   localparam logic [3:0] OP_BZ = 4'h6;
   localparam logic [3:0] OP_CALL = 4'h7;
   localparam logic [3:0] OP_RET = 4'h8;
   localparam logic [3:0] OP_REPEAT = 4'h9;
   localparam logic [3:0] OP_DMOV = 4'ha;
   localparam logic [3:0] OP_TBL = 4'hb;
   localparam logic [3:0] OP_DIV = 4'hc;
   localparam logic [3:0] OP_ALU = 4'hd;
   typedef enum logic [3:0] {
      ALU_ADD = 4'h0,
      ALU_SUB = 4'h1,
      ALU_AND = 4'h2,
      ALU_OR = 4'h3,
      ALU_XOR = 4'h4,
      ALU_SHL = 4'h5,
      ALU_LSR = 4'h6,
      ALU_ASR = 4'h7,
      ALU_MOVA = 4'h8
   } alu_op_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_CALL2 = 3'b001,
      ST_RET2 = 3'b010,
      ST_DMOV2 = 3'b011,
      ST_IRQ2 = 3'b100
   } state_t;
endpackage

// [verilog/cpu_alu.sv]
// 16-bit two's complement arithmetic and logic unit
`timescale 1ns/1ps
module cpu_alu import cpu_core_pkg::*; (
   // Operands
   input wire logic [15:0] a_i,
   input wire logic [15:0] b_i,
   input wire logic [3:0] op_i,
   // Result and flags
   output logic [15:0] y_o,
   output logic c_o,
   output logic ov_o,
   output logic z_o,
   output logic n_o
);
   logic [16:0] sum;
   logic [16:0] dif;

   always_comb begin
      sum = {1'b0, a_i} + {1'b0, b_i};
      dif = {1'b0, a_i} - {1'b0, b_i};
      c_o = 1'b0;
      ov_o = 1'b0;
      case (op_i)
         ALU_ADD: begin
            y_o = sum[15:0];
            c_o = sum[16];
            ov_o = (a_i[15] == b_i[15]) && (sum[15] != a_i[15]);
         end
         ALU_SUB: begin
            // Carry set means no borrow
            y_o = dif[15:0];
            c_o = ~dif[16];
            ov_o = (a_i[15] != b_i[15]) && (dif[15] != a_i[15]);
         end
         ALU_AND: y_o = a_i & b_i;
         ALU_OR: y_o = a_i | b_i;
         ALU_XOR: y_o = a_i ^ b_i;
         ALU_SHL: y_o = a_i << b_i[3:0];
         ALU_LSR: y_o = a_i >> b_i[3:0];
         ALU_ASR: y_o = $signed(a_i) >>> b_i[3:0];
         ALU_MOVA: y_o = a_i;
         default: y_o = a_i;
      endcase
      z_o = (y_o == 16'h0000);
      n_o = y_o[15];
   end
endmodule

// [verilog/cpu_core.sv]
// Fetch and execute core with prefetch, repeat loop and working registers
`timescale 1ns/1ps
module cpu_core import cpu_core_pkg::*; (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // Program memory
   output logic [22:0] PMEM_ADDR_O,
   input wire logic [23:0] PMEM_DATA_I,
   // Data memory
   output logic [15:0] DMEM_RADDR_O,
   input wire logic [15:0] DMEM_RDATA_I,
   output logic [15:0] DMEM_WADDR_O,
   output logic [15:0] DMEM_WDATA_O,
   output logic DMEM_WE_O,
   // Interrupt
   input wire logic IRQ_I,
   output logic IRQ_ACK_O,
   // Status
   output logic REPEAT_ACTIVE_O,
   output logic IN_ISR_O
);
   logic [15:0] wreg [NREG];
   state_t st_reg, st_next;
   logic [22:0] pc_reg, pc_next, irpc_reg, irpc_next;
   logic [23:0] ir_reg, ir_next;
   logic irv_reg, irv_next;
   logic ra_reg, ra_next, sra_reg, sra_next, isr_reg, isr_next;
   logic [15:0] rc_reg, rc_next;
   logic [6:0] rhi_reg, rhi_next;
   logic z_reg, z_next, n_reg, n_next, c_reg, c_next, ov_reg, ov_next;
   logic w0_en, w1_en;
   logic [3:0] w0_idx, w1_idx;
   logic [15:0] w0_dat, w1_dat;
   logic [3:0] op, sub, wd, wa, wb;
   logic [15:0] lit, sp, ra_w, rb_w, rd_w, alu_a, alu_y, dmov_a;
   logic alu_c, alu_ov, alu_z, alu_n;
   logic [22:0] tgt, ret_pc, tbl_addr;
   logic [23:0] fetch_w, tbl_w;
   logic exec, irq_take, hold, fetch;
   logic [16:0] dv_t;
   logic dv_ge;

   // Fixed 4-bit opcode: major field, then sub-op or register fields
   assign op = ir_reg[F_OP +: 4];
   assign sub = ir_reg[F_SUB +: 4];
   assign wd = ir_reg[F_WD +: 4];
   assign wa = ir_reg[F_WA +: 4];
   assign wb = ir_reg[F_WB +: 4];
   assign lit = ir_reg[15:0];
   assign tgt = {3'b000, ir_reg[19:0]};
   assign ra_w = wreg[wa];
   assign rb_w = wreg[wb];
   assign rd_w = wreg[wd];
   assign sp = wreg[SP_IDX];
   assign ret_pc = 23'(irpc_reg + 23'h000001);
   assign dmov_a = 16'(ra_w + WORD_STEP);
   assign tbl_addr = {rb_w[6:0], ra_w};
   // Words outside the implemented space read back as no-operation
   assign fetch_w = (pc_reg < PROG_IMPL_WORDS) ? PMEM_DATA_I : INSTR_NOP;
   assign tbl_w = (tbl_addr < PROG_IMPL_WORDS) ? PMEM_DATA_I : INSTR_NOP;
   assign irq_take = IRQ_I && !isr_reg && irv_reg && (st_reg == ST_RUN);
   assign exec = irv_reg && (st_reg == ST_RUN) && !irq_take;
   assign hold = ra_reg && (rc_reg != 16'h0000);
   assign alu_a = (op == OP_MEMALU) ? DMEM_RDATA_I : ra_w;
   assign dv_t = {wreg[1], wreg[0][15]};
   assign dv_ge = dv_t >= {1'b0, rb_w};

   cpu_alu u_alu (
      .a_i(alu_a),
      .b_i(rb_w),
      .op_i(op == OP_ALU || op == OP_MEMALU ? sub : 4'(ALU_MOVA)),
      .y_o(alu_y),
      .c_o(alu_c),
      .ov_o(alu_ov),
      .z_o(alu_z),
      .n_o(alu_n)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      pc_next = pc_reg;
      ir_next = ir_reg;
      irv_next = irv_reg;
      irpc_next = irpc_reg;
      ra_next = ra_reg;
      sra_next = sra_reg;
      isr_next = isr_reg;
      rc_next = rc_reg;
      rhi_next = rhi_reg;
      {z_next, n_next, c_next, ov_next} = {z_reg, n_reg, c_reg, ov_reg};
      {w0_en, w1_en} = 2'b00;
      w0_idx = wd;
      w1_idx = SP_IDX;
      w0_dat = 16'h0000;
      w1_dat = 16'h0000;
      PMEM_ADDR_O = pc_reg;
      DMEM_RADDR_O = ra_w;
      DMEM_WADDR_O = sp;
      DMEM_WDATA_O = 16'h0000;
      DMEM_WE_O = 1'b0;
      IRQ_ACK_O = 1'b0;
      fetch = 1'b0;
      case (st_reg)
         ST_RUN: begin
            if (irq_take) begin
               // Save the not-yet-run instruction's address; count stays put
               IRQ_ACK_O = 1'b1;
               DMEM_WE_O = 1'b1;
               DMEM_WDATA_O = irpc_reg[15:0];
               w1_en = 1'b1;
               w1_dat = 16'(sp + STACK_STEP);
               sra_next = ra_reg;
               ra_next = 1'b0;
               isr_next = 1'b1;
               irv_next = 1'b0;
               st_next = ST_IRQ2;
            end else if (!irv_reg) begin
               fetch = 1'b1;
            end else begin
               fetch = 1'b1;
               case (op)
                  OP_ALU: begin
                     // Two sources and a separate destination in one cycle
                     w0_en = 1'b1;
                     w0_dat = alu_y;
                     {z_next, n_next, c_next, ov_next} = {alu_z, alu_n, alu_c, alu_ov};
                  end
                  OP_LIT: begin
                     w0_en = 1'b1;
                     w0_idx = ir_reg[F_SUB +: 4];
                     w0_dat = lit;
                  end
                  OP_LOAD: begin
                     // Base pointer plus offset register
                     DMEM_RADDR_O = 16'(ra_w + rb_w);
                     w0_en = 1'b1;
                     w0_dat = DMEM_RDATA_I;
                  end
                  OP_MEMALU: begin
                     // Memory read, register read, memory write and fetch at once
                     DMEM_WE_O = 1'b1;
                     DMEM_WADDR_O = rd_w;
                     DMEM_WDATA_O = alu_y;
                     {z_next, n_next, c_next, ov_next} = {alu_z, alu_n, alu_c, alu_ov};
                  end
                  OP_STORE: begin
                     DMEM_WE_O = 1'b1;
                     DMEM_WADDR_O = 16'(ra_w + rb_w);
                     DMEM_WDATA_O = rd_w;
                  end
                  OP_GOTO: begin
                     fetch = 1'b0;
                     pc_next = tgt;
                     irv_next = 1'b0;
                  end
                  OP_BZ: begin
                     if (z_reg) begin
                        fetch = 1'b0;
                        pc_next = 23'(irpc_reg + {{7{lit[15]}}, lit});
                        irv_next = 1'b0;
                     end
                  end
                  OP_CALL: begin
                     fetch = 1'b0;
                     DMEM_WE_O = 1'b1;
                     DMEM_WDATA_O = ret_pc[15:0];
                     w1_en = 1'b1;
                     w1_dat = 16'(sp + STACK_STEP);
                     irv_next = 1'b0;
                     st_next = ST_CALL2;
                  end
                  OP_RET: begin
                     fetch = 1'b0;
                     DMEM_RADDR_O = 16'(sp - STACK_STEP);
                     rhi_next = DMEM_RDATA_I[6:0];
                     w1_en = 1'b1;
                     w1_dat = 16'(sp - STACK_STEP);
                     irv_next = 1'b0;
                     st_next = ST_RET2;
                  end
                  OP_REPEAT: begin
                     ra_next = 1'b1;
                     rc_next = lit;
                  end
                  OP_DMOV: begin
                     fetch = 1'b0;
                     w0_en = 1'b1;
                     w0_dat = DMEM_RDATA_I;
                     st_next = ST_DMOV2;
                  end
                  OP_TBL: begin
                     // Program port serves the table access, so no fetch here
                     fetch = 1'b0;
                     PMEM_ADDR_O = tbl_addr;
                     w0_en = 1'b1;
                     w0_dat = sub[0] ? {8'h00, tbl_w[23:16]} : tbl_w[15:0];
                     irv_next = 1'b0;
                  end
                  OP_DIV: begin
                     // One quotient bit per step; state lives in W1:W0 only
                     if (!ra_reg || rc_reg <= DIV_STEP_LAST) begin
                        w0_en = 1'b1;
                        w0_idx = 4'h0;
                        w0_dat = {wreg[0][14:0], dv_ge};
                        w1_en = 1'b1;
                        w1_idx = 4'h1;
                        w1_dat = dv_ge ? 16'(dv_t - {1'b0, rb_w}) : dv_t[15:0];
                     end
                  end
                  default: ;
               endcase
               if (fetch && hold && op != OP_REPEAT) begin
                  // Re-run the same word with no fetch overhead
                  fetch = 1'b0;
                  rc_next = 16'(rc_reg - 16'h0001);
               end else if (fetch && ra_reg && op != OP_REPEAT) begin
                  ra_next = 1'b0;
               end
            end
         end
         ST_CALL2: begin
            DMEM_WE_O = 1'b1;
            DMEM_WDATA_O = {9'h000, ret_pc[22:16]};
            w1_en = 1'b1;
            w1_dat = 16'(sp + STACK_STEP);
            pc_next = tgt;
            st_next = ST_RUN;
         end
         ST_IRQ2: begin
            DMEM_WE_O = 1'b1;
            DMEM_WDATA_O = {9'h000, irpc_reg[22:16]};
            w1_en = 1'b1;
            w1_dat = 16'(sp + STACK_STEP);
            pc_next = IRQ_VECTOR;
            st_next = ST_RUN;
         end
         ST_RET2: begin
            DMEM_RADDR_O = 16'(sp - STACK_STEP);
            w1_en = 1'b1;
            w1_dat = 16'(sp - STACK_STEP);
            pc_next = {rhi_reg, DMEM_RDATA_I};
            if (ir_reg[F_RETI]) begin
               isr_next = 1'b0;
               ra_next = sra_reg;
            end
            st_next = ST_RUN;
         end
         ST_DMOV2: begin
            DMEM_RADDR_O = dmov_a;
            w0_en = 1'b1;
            w0_idx = 4'(wd + 4'h1);
            w0_dat = DMEM_RDATA_I;
            fetch = 1'b1;
            st_next = ST_RUN;
         end
         default: st_next = ST_RUN;
      endcase
      if (fetch) begin
         ir_next = fetch_w;
         irv_next = 1'b1;
         irpc_next = pc_reg;
         pc_next = 23'(pc_reg + 23'h000001);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         st_reg <= ST_RUN;
         pc_reg <= RESET_VECTOR;
         ir_reg <= INSTR_NOP;
         irv_reg <= 1'b0;
         irpc_reg <= RESET_VECTOR;
         ra_reg <= 1'b0;
         sra_reg <= 1'b0;
         isr_reg <= 1'b0;
         rc_reg <= 16'h0000;
         rhi_reg <= 7'h00;
         {z_reg, n_reg, c_reg, ov_reg} <= 4'h0;
      end else begin
         st_reg <= st_next;
         pc_reg <= pc_next;
         ir_reg <= ir_next;
         irv_reg <= irv_next;
         irpc_reg <= irpc_next;
         ra_reg <= ra_next;
         sra_reg <= sra_next;
         isr_reg <= isr_next;
         rc_reg <= rc_next;
         rhi_reg <= rhi_next;
         {z_reg, n_reg, c_reg, ov_reg} <= {z_next, n_next, c_next, ov_next};
      end
   end

   // Working register file, two write ports
   for (genvar gi = 0; gi < NREG; gi++) begin : g_wreg
      always_ff @(posedge REF_CLK_I) begin
         if (RST_I) begin
            wreg[gi] <= 16'h0000;
         end else if (w1_en && w1_idx == 4'(gi)) begin
            wreg[gi] <= w1_dat;
         end else if (w0_en && w0_idx == 4'(gi)) begin
            wreg[gi] <= w0_dat;
         end
      end
   end

   assign REPEAT_ACTIVE_O = ra_reg;
   assign IN_ISR_O = isr_reg;

   ////////////////////////////////////////////////////////////////////////
   AST_PC_STEP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && fetch) |=> pc_reg == 23'($past(pc_reg) + 23'h000001))
      else $error("pc did not advance by one");
   AST_IMPL_NOP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (fetch && pc_reg >= PROG_IMPL_WORDS) |=> ir_reg == INSTR_NOP)
      else $error("unimplemented word not fetched as nop");
   AST_PREFETCH: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_GOTO) |=> !irv_reg ##1 (irv_reg && irpc_reg == $past(pc_reg)))
      else $error("flush did not refill in one cycle");
   AST_CALL_TWO: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_CALL) |=> st_reg == ST_CALL2 ##1 (st_reg == ST_RUN && pc_reg == $past(tgt)))
      else $error("call not two cycles");
   AST_REPEAT_LOAD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_REPEAT) |=> ra_reg && rc_reg == $past(lit))
      else $error("repeat count not loaded");
   AST_LOAD_ADDR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_LOAD) |=> wreg[$past(wd)] == $past(DMEM_RDATA_I) && $past(DMEM_RADDR_O) == $past(16'(ra_w + rb_w)))
      else $error("indexed load wrong");
   AST_SP_PUSH: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      irq_take |=> ##1 wreg[SP_IDX] == 16'($past(sp, 2) + 16'h0004))
      else $error("stack pointer not bumped twice");
   AST_MEM_PAR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_MEMALU) |-> DMEM_WE_O && DMEM_WDATA_O == alu_y && (fetch || hold))
      else $error("memory op lost a parallel access");
   AST_THREE_OP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_ALU && sub == ALU_ADD) |=> wreg[$past(wd)] == 16'($past(ra_w) + $past(rb_w)))
      else $error("three-operand add wrong");
   AST_DIV_END: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (exec && op == OP_DIV && ra_reg && rc_reg == 16'h0000) |=> !ra_reg && irpc_reg == $past(pc_reg))
      else $error("divide loop did not end");
   AST_IRQ_KEEP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (irq_take && ra_reg) |=> sra_reg && rc_reg == $past(rc_reg))
      else $error("repeat state lost on interrupt");
endmodule

// [sim/cpu_mem_model.sv]
// Program and data memory model facing the core
`timescale 1ns/1ps
module cpu_mem_model (
   // Clock
   input wire logic clk_i,
   // Program port
   input wire logic [22:0] paddr_i,
   output logic [23:0] pdata_o,
   // Data port
   input wire logic [15:0] raddr_i,
   output logic [15:0] rdata_o,
   input wire logic [15:0] waddr_i,
   input wire logic [15:0] wdata_i,
   input wire logic we_i
);
   logic [23:0] prog [256];
   logic [15:0] data [256];
   logic flip = 1'b0;
   always @(posedge clk_i) begin
      flip <= ~flip;
      // Write port works beside the read port in the same cycle
      if (we_i === 1'b1) begin
         data[waddr_i[8:1]] <= wdata_i;
      end
   end
   // Nothing is fitted outside the first words, so a changing pattern shows there
   assign pdata_o = (paddr_i < 23'h000100) ? prog[paddr_i[7:0]] : {24{flip}};
   assign rdata_o = data[raddr_i[8:1]];
endmodule

// [sim/tb.sv]
// Self-checking bench of the fetch and execute core
`timescale 1ns/1ps
module tb import cpu_core_pkg::*; ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic irq = 1'b0;
   logic [22:0] paddr;
   logic [23:0] pdata;
   logic [15:0] raddr, rdata, waddr, wdata;
   logic we, ack, rpt, isr;
   logic [23:0] prg [256];
   logic [15:0] wq_a [$];
   logic [15:0] wq_d [$];
   int pa;
   int n_errors = 0;
   int compares = 0;

   initial begin
      forever #10 clk = ~clk;
   end

   cpu_core dut_u (.REF_CLK_I(clk), .RST_I(rst), .PMEM_ADDR_O(paddr), .PMEM_DATA_I(pdata),
      .DMEM_RADDR_O(raddr), .DMEM_RDATA_I(rdata), .DMEM_WADDR_O(waddr), .DMEM_WDATA_O(wdata),
      .DMEM_WE_O(we), .IRQ_I(irq), .IRQ_ACK_O(ack), .REPEAT_ACTIVE_O(rpt), .IN_ISR_O(isr));
   cpu_mem_model mem_u (.clk_i(clk), .paddr_i(paddr), .pdata_o(pdata), .raddr_i(raddr),
      .rdata_o(rdata), .waddr_i(waddr), .wdata_i(wdata), .we_i(we));

   always @(posedge clk) begin
      if (we === 1'b1) begin
         wq_a.push_back(waddr);
         wq_d.push_back(wdata);
      end
   end
//////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] ins(logic [3:0] op, sub, d, a, b);
      return {op, sub, d, a, b, 4'h0};
   endfunction
   function automatic logic [23:0] lit(logic [3:0] r, logic [15:0] v);
      return {OP_LIT, r, v};
   endfunction
   task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wait_addr(logic [22:0] a, output int n);
      n = 0;
      while (paddr !== a) begin
         @(posedge clk);
         #2;
         n++;
         if (n > 2000) begin
            chk("fetch address", {1'b0, paddr}, {1'b0, a});
            close_out();
         end
      end
   endtask
   task automatic clr(int first);
      foreach (prg[i]) prg[i] = INSTR_NOP;
      pa = first;
   endtask
   task automatic put(logic [23:0] w);
      prg[pa] = w;
      pa++;
   endtask
   // Ends the program in a jump to itself, then restarts the core on it
   task automatic start();
      prg[pa] = {OP_GOTO, 20'(pa)};
      @(posedge clk);
      #1 rst = 1'b1;
      foreach (prg[i]) mem_u.prog[i] = prg[i];
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      wq_a.delete();
      wq_d.delete();
   endtask
   task automatic finish();
      int n;
      wait_addr(23'(pa), n);
      repeat (10) @(posedge clk);
      #2;
   endtask
//////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("reset pc and strobe", {paddr, we}, 24'h000000);
      chk("reset flags", {21'h0, ack, rpt, isr}, 24'h000000);
      $display("test reset done");
   endtask
   task automatic t_alu();
      logic [3:0] ops [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h5, 4'h6, 4'h7};
      logic [15:0] res [9] = '{16'h8100, 16'h7f02, 16'h0001, 16'h80ff, 16'h80fe, 16'h8001, 16'h8000, 16'h0001,
         16'hffff};
      logic [23:0] w [15] = '{lit(4'h8, 16'h0020), ins(OP_LOAD, 4'h0, 4'h9, 4'h8, 4'h0),
         lit(4'h5, 16'h0060), ins(OP_STORE, 4'h0, 4'h9, 4'h5, 4'h0), lit(4'ha, 16'h0062),
         ins(OP_MEMALU, 4'h0, 4'ha, 4'h8, 4'h2), lit(4'hb, 16'h0050),
         ins(OP_TBL, 4'h0, 4'hc, 4'hb, 4'h0), lit(4'h5, 16'h0064), ins(OP_STORE, 4'h0, 4'hc, 4'h5, 4'h0),
         ins(OP_TBL, 4'h1, 4'hc, 4'hb, 4'h0), lit(4'h5, 16'h0066), ins(OP_STORE, 4'h0, 4'hc, 4'h5, 4'h0),
         ins(OP_DMOV, 4'h0, 4'hd, 4'h8, 4'h0), ins(OP_STORE, 4'h0, 4'he, 4'h5, 4'h5)};
      clr(0);
      put(lit(4'h1, 16'h8001));
      put(lit(4'h2, 16'h00ff));
      put(lit(4'h4, 16'h0040));
      for (int k = 0; k < 9; k++) begin
         put(ins(OP_ALU, ops[k], 4'h3, 4'h1, 4'h2));
         put(lit(4'h5, 16'(2 * k)));
         put(ins(OP_STORE, 4'h0, 4'h3, 4'h4, 4'h5));
      end
      foreach (w[i]) put(w[i]);
      prg[8'h50] = 24'habcdef;
      mem_u.data[8'h10] = 16'h1234;
      mem_u.data[8'h11] = 16'h4321;
      start();
      finish();
      for (int k = 0; k < 9; k++) begin
         chk("alu result", {8'h0, mem_u.data[8'h20 + k]}, {8'h0, res[k]});
      end
      chk("indexed load", {8'h0, mem_u.data[8'h30]}, 24'h001234);
      chk("memory alu", {8'h0, mem_u.data[8'h31]}, 24'h001333);
      chk("table low", {8'h0, mem_u.data[8'h32]}, 24'h00cdef);
      chk("table high", {8'h0, mem_u.data[8'h33]}, 24'h0000ab);
      chk("double move", {8'h0, mem_u.data[8'h66]}, 24'h004321);
      $display("test alu done");
   endtask
   task automatic t_timing();
      logic [23:0] w [7] = '{INSTR_NOP, ins(OP_ALU, 4'h0, 4'h3, 4'h1, 4'h2), ins(OP_LOAD, 4'h0, 4'h3, 4'h1, 4'h2),
         ins(OP_MEMALU, 4'h0, 4'h3, 4'h1, 4'h2), ins(OP_DMOV, 4'h0, 4'h3, 4'h1, 4'h0),
         ins(OP_TBL, 4'h0, 4'h3, 4'h1, 4'h0), {OP_BZ, 4'h0, 16'h0001}};
      int cyc [7] = '{4, 4, 4, 4, 5, 5, 5};
      int n;
      for (int k = 0; k < 7; k++) begin
         clr(12);
         // Zero result sets the flag, so the branch case is taken to the next word
         prg[2] = ins(OP_ALU, 4'h1, 4'h3, 4'h0, 4'h0);
         prg[3] = w[k];
         start();
         wait_addr(23'h000002, n);
         wait_addr(23'h000006, n);
         chk("cycles", 24'(n), 24'(cyc[k]));
      end
      $display("test timing done");
   endtask
   task automatic t_call();
      logic [15:0] ea [3] = '{16'h0100, 16'h0102, 16'h0000};
      logic [15:0] ed [3] = '{16'h0002, 16'h0000, 16'h5a5a};
      clr(3);
      prg[0] = lit(4'hf, 16'h0100);
      prg[1] = {OP_CALL, 20'h00020};
      prg[2] = ins(OP_STORE, 4'h0, 4'h1, 4'h0, 4'h0);
      prg[8'h20] = lit(4'h1, 16'h5a5a);
      prg[8'h21] = {OP_RET, 20'h00000};
      start();
      finish();
      chk("write count", 24'(wq_a.size()), 24'h000003);
      for (int k = 0; k < 3 && k < wq_a.size(); k++) begin
         chk("write address", {8'h0, wq_a[k]}, {8'h0, ea[k]});
         chk("write data", {8'h0, wq_d[k]}, {8'h0, ed[k]});
      end
      $display("test call done");
   endtask
   task automatic t_unfitted();
      int n;
      clr(1);
      prg[0] = {OP_GOTO, 20'h08000};
      start();
      wait_addr(23'h008001, n);
      wait_addr(23'h008005, n);
      chk("unfitted cycles", 24'(n), 24'h000004);
      chk("unfitted writes", 24'(wq_a.size()), 24'h000000);
      $display("test unfitted done");
   endtask
   task automatic t_repeat();
      int n;
      clr(4);
      prg[0] = lit(4'h2, 16'h0001);
      prg[1] = {OP_REPEAT, 4'h0, 16'h0003};
      prg[2] = ins(OP_ALU, 4'h0, 4'h1, 4'h1, 4'h2);
      prg[3] = ins(OP_STORE, 4'h0, 4'h1, 4'h0, 4'h0);
      start();
      wait_addr(23'h000001, n);
      wait_addr(23'h000004, n);
      chk("repeat cycles", 24'(n), 24'h000006);
      finish();
      chk("repeat sum", {8'h0, mem_u.data[0]}, 24'h000004);
      $display("test repeat done");
   endtask
   task automatic t_div(bit with_irq);
      logic [23:0] w [8] = '{lit(4'hf, 16'h0080), lit(4'h0, 16'h0064), lit(4'h2, 16'h0007),
         lit(4'h5, 16'h0002), {OP_REPEAT, 4'h0, 16'h0011}, ins(OP_DIV, 4'h0, 4'h0, 4'h0, 4'h2),
         ins(OP_STORE, 4'h0, 4'h0, 4'h3, 4'h4), ins(OP_STORE, 4'h0, 4'h1, 4'h5, 4'h4)};
      int n;
      clr(16);
      prg[0] = {OP_GOTO, 20'h00010};
      prg[4] = {OP_RET, 4'h8, 16'h0000};
      foreach (w[i]) put(w[i]);
      start();
      wait_addr(23'h000014, n);
      if (with_irq) begin
         repeat (8) @(posedge clk);
         #1;
         chk("repeat active", {23'h0, rpt}, 24'h000001);
         irq = 1'b1;
         #1;
         for (int i = 0; i < 20 && ack !== 1'b1; i++) begin
            @(posedge clk);
            #2;
         end
         chk("irq taken", {23'h0, ack}, 24'h000001);
         if (ack !== 1'b1) begin
            close_out();
         end
         @(posedge clk);
         #1 irq = 1'b0;
         #1;
         chk("in service", {23'h0, isr}, 24'h000001);
         finish();
         chk("push address", {wq_a[0], wq_a[1][7:0]}, 24'h008082);
         chk("pushed pc", {8'h0, wq_d[0]}, 24'h000015);
         chk("service ended", {22'h0, isr, rpt}, 24'h000000);
      end else begin
         wait_addr(23'h000017, n);
         chk("divide cycles", 24'(n), 24'h000014);
         finish();
      end
      chk("quotient", {8'h0, mem_u.data[0]}, 24'h00000e);
      chk("remainder", {8'h0, mem_u.data[1]}, 24'h000002);
      $display("test divide done");
   endtask
//////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      #2;
      t_reset();
      t_alu();
      t_timing();
      t_call();
      t_unfitted();
      t_repeat();
      t_div(1'b0);
      t_div(1'b1);
      close_out();
   end
endmodule
